// *** rtl/fmt_regs.sv ***
// format and output control register bank of the video decoder
`timescale 1ns/1ns
`default_nettype none
module fmt_regs #(
    parameter logic [7:0] PRODUCT_IDENTIFIER = 8'h5A // arbitrary identifier value
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [1:0]  i_detected_std,
    input  wire logic [15:0] i_pixel,
    input  wire logic [6:0]  i_timing,
    output logic [7:0]       o_reg_rdata,
    output logic             o_reg_rvalid,
    output logic [1:0]       o_timing_std,
    output logic             o_pedestal_75,
    output logic             o_adaptive_slice,
    output logic [2:0]       o_pixel_format,
    output logic [1:0]       o_gamma_sel,
    output logic             o_gamma_en,
    output logic [1:0]       o_color_sel,
    output logic [15:0]      o_pixel_bus,
    output logic             o_pixel_bus_oe,
    output logic [6:0]       o_timing,
    output logic             o_timing_oe
);
    typedef struct packed {
        logic [7:0] in_fmt;
        logic [7:0] out_fmt;
        logic [7:0] pin_ctl;
        logic [1:0] det_meta;
        logic [1:0] det_sync;
        logic [7:0] rdata;
        logic       rvalid;
        logic [1:0] std;
        logic       ped;
        logic       slice;
        logic [2:0] pfmt;
        logic [1:0] gamma;
        logic       gamma_en;
        logic [1:0] csel;
    } reg_state_t;

    reg_state_t state;
    reg_state_t next_state;
    logic [7:0] in_fmt_view;

    fmt_cfg_if cfg ();

    // live standard: detected value while auto-detect is on
    always_comb begin
        in_fmt_view = state.in_fmt & fmt_regs_pkg::MASK_INPUT_FORMAT;
        if (state.in_fmt[fmt_regs_pkg::AUTO_BIT]) begin
            in_fmt_view[fmt_regs_pkg::STD_HI:fmt_regs_pkg::STD_LO] = state.det_sync;
        end
    end

    // register writes, reads and decoded configuration
    always_comb begin
        next_state          = state;
        next_state.det_meta = i_detected_std;
        next_state.det_sync = state.det_meta;
        next_state.rvalid   = i_reg_rd;
        if (i_reg_wr) begin
            case (i_reg_addr)
                fmt_regs_pkg::ADDR_INPUT_FORMAT_CONFIG: begin
                    next_state.in_fmt = i_reg_wdata & fmt_regs_pkg::MASK_INPUT_FORMAT;
                    if (i_reg_wdata[fmt_regs_pkg::AUTO_BIT] ||
                        state.in_fmt[fmt_regs_pkg::AUTO_BIT]) begin
                        // field locked while detection is on or is being switched on by this write
                        next_state.in_fmt[fmt_regs_pkg::STD_HI:fmt_regs_pkg::STD_LO] =
                            state.in_fmt[fmt_regs_pkg::STD_HI:fmt_regs_pkg::STD_LO];
                    end
                end
                fmt_regs_pkg::ADDR_OUTPUT_FORMAT_CONFIG: next_state.out_fmt = i_reg_wdata;
                fmt_regs_pkg::ADDR_OUTPUT_PIN_CONTROL:   next_state.pin_ctl = i_reg_wdata;
                default: next_state.in_fmt = state.in_fmt; // identifier and unused: dropped
            endcase
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                fmt_regs_pkg::ADDR_PRODUCT_IDENTIFIER:   next_state.rdata = PRODUCT_IDENTIFIER;
                fmt_regs_pkg::ADDR_INPUT_FORMAT_CONFIG:  next_state.rdata = in_fmt_view;
                fmt_regs_pkg::ADDR_OUTPUT_FORMAT_CONFIG: next_state.rdata = state.out_fmt;
                fmt_regs_pkg::ADDR_OUTPUT_PIN_CONTROL:   next_state.rdata = state.pin_ctl;
                default:                                 next_state.rdata = 8'h00;
            endcase
        end
        // manual standard when auto bit is 0, detected otherwise
        next_state.std   = in_fmt_view[fmt_regs_pkg::STD_HI:fmt_regs_pkg::STD_LO];
        next_state.ped   = state.in_fmt[fmt_regs_pkg::SETUP_BIT];
        next_state.slice = state.in_fmt[fmt_regs_pkg::SLICE_BIT];
        next_state.pfmt  = state.out_fmt[fmt_regs_pkg::PFMT_HI:fmt_regs_pkg::PFMT_LO];
        next_state.gamma_en = fmt_regs_pkg::is_rgb(
            state.out_fmt[fmt_regs_pkg::PFMT_HI:fmt_regs_pkg::PFMT_LO]);
        next_state.gamma = next_state.gamma_en ?
            state.out_fmt[fmt_regs_pkg::GAMMA_HI:fmt_regs_pkg::GAMMA_LO] :
            fmt_regs_pkg::GAMMA_LIN22;
        next_state.csel  = state.out_fmt[fmt_regs_pkg::CSEL_HI:fmt_regs_pkg::CSEL_LO];
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state          <= '0;
            state.in_fmt   <= fmt_regs_pkg::RST_INPUT_FORMAT;
            state.out_fmt  <= fmt_regs_pkg::RST_OUTPUT_FORMAT;
            state.pin_ctl  <= fmt_regs_pkg::RST_PIN_CONTROL;
            state.ped      <= fmt_regs_pkg::RST_INPUT_FORMAT[fmt_regs_pkg::SETUP_BIT];
            state.slice    <= fmt_regs_pkg::RST_INPUT_FORMAT[fmt_regs_pkg::SLICE_BIT];
        end else begin
            state <= next_state;
        end
    end

    // configuration handed to the pin stage
    assign cfg.pix_oe = state.pin_ctl[fmt_regs_pkg::PIX_OE_BIT];
    assign cfg.tim_oe = state.pin_ctl[fmt_regs_pkg::TIM_OE_BIT];
    assign cfg.pol    = {state.pin_ctl[fmt_regs_pkg::QUAL_POL],
                         state.pin_ctl[fmt_regs_pkg::ANC_POL],
                         state.pin_ctl[fmt_regs_pkg::FIELD_POL],
                         state.pin_ctl[fmt_regs_pkg::BLANK_POL],
                         state.pin_ctl[fmt_regs_pkg::FSYNC_POL],
                         state.pin_ctl[fmt_regs_pkg::LSYNC_POL]};

    fmt_pin_stage u_pins (
        .i_clk_sys      (i_clk_sys),
        .i_reset        (i_reset),
        .cfg            (cfg),
        .i_pixel        (i_pixel),
        .i_timing       (i_timing),
        .o_pixel_bus    (o_pixel_bus),
        .o_pixel_bus_oe (o_pixel_bus_oe),
        .o_timing       (o_timing),
        .o_timing_oe    (o_timing_oe)
    );

    assign o_reg_rdata      = state.rdata;
    assign o_reg_rvalid     = state.rvalid;
    assign o_timing_std     = state.std;
    assign o_pedestal_75    = state.ped;
    assign o_adaptive_slice = state.slice;
    assign o_pixel_format   = state.pfmt;
    assign o_gamma_sel      = state.gamma;
    assign o_gamma_en       = state.gamma_en;
    assign o_color_sel      = state.csel;

    // assertions
    property p_id_read;
        @(posedge i_clk_sys) disable iff (i_reset)
        (i_reg_rd && i_reg_addr == fmt_regs_pkg::ADDR_PRODUCT_IDENTIFIER)
            |=> (o_reg_rdata == PRODUCT_IDENTIFIER && o_reg_rvalid);
    endproperty
    a_id_read: assert property (p_id_read) else $error("identifier read wrong");

    property p_std_locked;
        @(posedge i_clk_sys) disable iff (i_reset)
        state.in_fmt[fmt_regs_pkg::AUTO_BIT] |=>
            $stable(state.in_fmt[fmt_regs_pkg::STD_HI:fmt_regs_pkg::STD_LO]);
    endproperty
    a_std_locked: assert property (p_std_locked) else $error("standard changed in auto");

    property p_std_out;
        @(posedge i_clk_sys) disable iff (i_reset)
        !state.in_fmt[fmt_regs_pkg::AUTO_BIT] |=>
            o_timing_std == $past(state.in_fmt[fmt_regs_pkg::STD_HI:fmt_regs_pkg::STD_LO]);
    endproperty
    a_std_out: assert property (p_std_out) else $error("manual standard not used");

    property p_gamma_off;
        @(posedge i_clk_sys) disable iff (i_reset)
        !fmt_regs_pkg::is_rgb(state.out_fmt[fmt_regs_pkg::PFMT_HI:fmt_regs_pkg::PFMT_LO])
            |=> !o_gamma_en;
    endproperty
    a_gamma_off: assert property (p_gamma_off) else $error("gamma active outside rgb");

    sequence s_pin_write(int b, logic v);
        i_reg_wr && i_reg_addr == fmt_regs_pkg::ADDR_OUTPUT_PIN_CONTROL && i_reg_wdata[b] == v;
    endsequence

    property p_pix_oe;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_pin_write(fmt_regs_pkg::PIX_OE_BIT, 1'b1) |=> ##1 o_pixel_bus_oe;
    endproperty
    a_pix_oe: assert property (p_pix_oe) else $error("pixel enable late");

    property p_tim_oe;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_pin_write(fmt_regs_pkg::TIM_OE_BIT, 1'b0) |=> ##1 !o_timing_oe;
    endproperty
    a_tim_oe: assert property (p_tim_oe) else $error("timing enable not cleared");

    property p_field_pol;
        @(posedge i_clk_sys) disable iff (i_reset)
        state.pin_ctl[fmt_regs_pkg::FIELD_POL] && $stable(state.pin_ctl) |=>
            o_timing[3] == $past(i_timing[3]);
    endproperty
    a_field_pol: assert property (p_field_pol) else $error("field polarity wrong");

    property p_lsync_pol;
        @(posedge i_clk_sys) disable iff (i_reset)
        !state.pin_ctl[fmt_regs_pkg::LSYNC_POL] && $stable(state.pin_ctl) |=>
            o_timing[0] == !$past(i_timing[0]);
    endproperty
    a_lsync_pol: assert property (p_lsync_pol) else $error("line sync polarity wrong");

    property p_rsvd_zero;
        @(posedge i_clk_sys) disable iff (i_reset)
        (i_reg_rd && i_reg_addr == fmt_regs_pkg::ADDR_INPUT_FORMAT_CONFIG)
            |=> (o_reg_rdata & ~fmt_regs_pkg::MASK_INPUT_FORMAT) == 8'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

    // writes leave the reserved input format bits clear
    property p_rsvd_write;
        @(posedge i_clk_sys) disable iff (i_reset)
        (i_reg_wr && i_reg_addr == fmt_regs_pkg::ADDR_INPUT_FORMAT_CONFIG)
            |=> (state.in_fmt & ~fmt_regs_pkg::MASK_INPUT_FORMAT) == 8'h00;
    endproperty
    a_rsvd_write: assert property (p_rsvd_write) else $error("reserved bits stored");

    // a write to the identifier place changes no stored register
    sequence s_id_write;
        i_reg_wr && i_reg_addr == fmt_regs_pkg::ADDR_PRODUCT_IDENTIFIER;
    endsequence

    property p_id_write;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_id_write |=> $stable(state.in_fmt) && $stable(state.out_fmt) &&
            $stable(state.pin_ctl);
    endproperty
    a_id_write: assert property (p_id_write) else $error("identifier write stored");

    // detected standard drives the output while auto-detect is on
    property p_std_auto;
        @(posedge i_clk_sys) disable iff (i_reset)
        state.in_fmt[fmt_regs_pkg::AUTO_BIT] |=> o_timing_std == $past(state.det_sync);
    endproperty
    a_std_auto: assert property (p_std_auto) else $error("detected standard not used");

    // configuration outputs follow the stored fields one edge later, gamma select only in the two rgb formats
    property p_ped_out;
        @(posedge i_clk_sys) disable iff (i_reset)
        1'b1 |=> o_pedestal_75 == $past(state.in_fmt[fmt_regs_pkg::SETUP_BIT]);
    endproperty
    a_ped_out: assert property (p_ped_out) else $error("pedestal select wrong");

    property p_slice_out;
        @(posedge i_clk_sys) disable iff (i_reset)
        1'b1 |=> o_adaptive_slice == $past(state.in_fmt[fmt_regs_pkg::SLICE_BIT]);
    endproperty
    a_slice_out: assert property (p_slice_out) else $error("slice select wrong");

    property p_pfmt_out;
        @(posedge i_clk_sys) disable iff (i_reset)
        1'b1 |=> o_pixel_format ==
            $past(state.out_fmt[fmt_regs_pkg::PFMT_HI:fmt_regs_pkg::PFMT_LO]);
    endproperty
    a_pfmt_out: assert property (p_pfmt_out) else $error("pixel format wrong");

    property p_gamma_on;
        @(posedge i_clk_sys) disable iff (i_reset)
        fmt_regs_pkg::is_rgb(state.out_fmt[fmt_regs_pkg::PFMT_HI:fmt_regs_pkg::PFMT_LO]) |=>
            o_gamma_en && o_gamma_sel ==
            $past(state.out_fmt[fmt_regs_pkg::GAMMA_HI:fmt_regs_pkg::GAMMA_LO]);
    endproperty
    a_gamma_on: assert property (p_gamma_on) else $error("gamma not applied in rgb");

    property p_csel_out;
        @(posedge i_clk_sys) disable iff (i_reset)
        1'b1 |=> o_color_sel ==
            $past(state.out_fmt[fmt_regs_pkg::CSEL_HI:fmt_regs_pkg::CSEL_LO]);
    endproperty
    a_csel_out: assert property (p_csel_out) else $error("colour select wrong");

    // enables follow the pin control bits two edges after the write
    property p_pix_off;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_pin_write(fmt_regs_pkg::PIX_OE_BIT, 1'b0) |=> ##1 !o_pixel_bus_oe;
    endproperty
    a_pix_off: assert property (p_pix_off) else $error("pixel enable not cleared");

    property p_tim_on;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_pin_write(fmt_regs_pkg::TIM_OE_BIT, 1'b1) |=> ##1 o_timing_oe;
    endproperty
    a_tim_on: assert property (p_tim_on) else $error("timing enable late");

    // pixel data and irq pass through one register stage unchanged
    property p_pix_pass;
        @(posedge i_clk_sys) disable iff (i_reset)
        1'b1 |=> o_pixel_bus == $past(i_pixel);
    endproperty
    a_pix_pass: assert property (p_pix_pass) else $error("pixel data not passed");

    property p_irq_pass;
        @(posedge i_clk_sys) disable iff (i_reset)
        1'b1 |=> o_timing[6] == $past(i_timing[6]);
    endproperty
    a_irq_pass: assert property (p_irq_pass) else $error("irq level altered");

    // polarity: a clear bit inverts the true-high level, a set bit passes it
    property p_field_low;
        @(posedge i_clk_sys) disable iff (i_reset)
        !state.pin_ctl[fmt_regs_pkg::FIELD_POL] && $stable(state.pin_ctl) |=>
            o_timing[3] == !$past(i_timing[3]);
    endproperty
    a_field_low: assert property (p_field_low) else $error("field not low in odd");

    property p_blank_pol;
        @(posedge i_clk_sys) disable iff (i_reset)
        1'b1 |=> o_timing[2] ==
            ($past(i_timing[2]) ~^ $past(state.pin_ctl[fmt_regs_pkg::BLANK_POL]));
    endproperty
    a_blank_pol: assert property (p_blank_pol) else $error("blank polarity wrong");

    property p_qual_pol;
        @(posedge i_clk_sys) disable iff (i_reset)
        1'b1 |=> o_timing[5] ==
            ($past(i_timing[5]) ~^ $past(state.pin_ctl[fmt_regs_pkg::QUAL_POL]));
    endproperty
    a_qual_pol: assert property (p_qual_pol) else $error("qualifier polarity wrong");
endmodule
`default_nettype wire

// *** rtl/fmt_regs_pkg.sv ***
// constants for the decoder format and output control register bank
package fmt_regs_pkg;
    localparam logic [7:0] ADDR_PRODUCT_IDENTIFIER   = 8'h00;
    localparam logic [7:0] ADDR_INPUT_FORMAT_CONFIG  = 8'h01;
    localparam logic [7:0] ADDR_OUTPUT_FORMAT_CONFIG = 8'h02;
    localparam logic [7:0] ADDR_OUTPUT_PIN_CONTROL   = 8'h03;

    // reset values and input format write mask
    localparam logic [7:0] RST_INPUT_FORMAT  = 8'h19;
    localparam logic [7:0] RST_OUTPUT_FORMAT = 8'h00;
    localparam logic [7:0] RST_PIN_CONTROL   = 8'h00;
    localparam logic [7:0] MASK_INPUT_FORMAT = 8'h79;

    // input format fields
    localparam int STD_HI       = 6;
    localparam int STD_LO       = 5;
    localparam int AUTO_BIT     = 4;
    localparam int SETUP_BIT    = 3;
    localparam int SLICE_BIT    = 0;
    // output format fields
    localparam int PFMT_HI      = 7;
    localparam int PFMT_LO      = 5;
    localparam int GAMMA_HI     = 4;
    localparam int GAMMA_LO     = 3;
    localparam int CSEL_HI      = 2;
    localparam int CSEL_LO      = 1;
    // pin control fields
    localparam int PIX_OE_BIT   = 7;
    localparam int TIM_OE_BIT   = 6;
    localparam int FIELD_POL    = 5;
    localparam int BLANK_POL    = 4;
    localparam int LSYNC_POL    = 3;
    localparam int FSYNC_POL    = 2;
    localparam int QUAL_POL     = 1;
    localparam int ANC_POL      = 0;

    typedef enum logic [1:0] {
        STD_NTSC_M  = 2'h0,
        STD_PAL_BDG = 2'h1,
        STD_PAL_M   = 2'h2,
        STD_PAL_NC  = 2'h3
    } timing_std_t;

    typedef enum logic [2:0] {
        PFMT_YCC16  = 3'h0,
        PFMT_YCC8   = 3'h1,
        PFMT_BT656  = 3'h2,
        PFMT_RGB15  = 3'h3,
        PFMT_RGB16  = 3'h4
    } pixel_fmt_t;

    typedef enum logic [1:0] {
        GAMMA_LIN22 = 2'h0,
        GAMMA_LIN28 = 2'h1,
        GAMMA_PASS  = 2'h2,
        GAMMA_RSVD  = 2'h3
    } gamma_t;

    typedef enum logic [1:0] {
        CSEL_NORMAL = 2'h0,
        CSEL_BLUE   = 2'h1,
        CSEL_BLACK  = 2'h2,
        CSEL_BARS   = 2'h3
    } color_sel_t;

    // true for the two rgb pixel formats
    function automatic logic is_rgb(input logic [2:0] fmt);
        return (fmt == PFMT_RGB15) || (fmt == PFMT_RGB16);
    endfunction
endpackage

// *** rtl/fmt_cfg_if.sv ***
// decoded configuration carried from the register bank to the pin stage
`timescale 1ns/1ns
`default_nettype none
interface fmt_cfg_if;
    logic       pix_oe;
    logic       tim_oe;
    logic [5:0] pol;
    modport src (output pix_oe, output tim_oe, output pol);
    modport dst (input pix_oe, input tim_oe, input pol);
endinterface
`default_nettype wire

// *** rtl/fmt_pin_stage.sv ***
// polarity and output enable stage for pixel bus and timing outputs
`timescale 1ns/1ns
`default_nettype none
module fmt_pin_stage (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset,
    fmt_cfg_if.dst           cfg,
    input  wire logic [15:0] i_pixel,
    input  wire logic [6:0]  i_timing,
    output logic [15:0]      o_pixel_bus,
    output logic             o_pixel_bus_oe,
    output logic [6:0]       o_timing,
    output logic             o_timing_oe
);
    typedef struct packed {
        logic [15:0] pix;
        logic        pix_oe;
        logic [6:0]  tim;
        logic        tim_oe;
    } pin_state_t;

    pin_state_t state;
    pin_state_t next_state;

    // timing order: 0 lsync,1 fsync,2 blank,3 field,4 anc,5 qual,6 irq (irq not inverted)
    always_comb begin
        next_state        = state;
        next_state.pix    = i_pixel;
        next_state.pix_oe = cfg.pix_oe;
        next_state.tim_oe = cfg.tim_oe;
        next_state.tim    = {i_timing[6], i_timing[5:0] ~^ cfg.pol};
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_pixel_bus    = state.pix;
    assign o_pixel_bus_oe = state.pix_oe;
    assign o_timing       = state.tim;
    assign o_timing_oe    = state.tim_oe;
endmodule
`default_nettype wire

// *** verif/host_model.sv ***
// host controller model driving the register strobe port of the bank
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata,
    output logic            o_wr,
    output logic            o_rd
);
    // idle bus at time zero
    initial begin
        o_addr  = 8'h00;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end

    // one write strobe for a single edge; output format bit 0 kept clear
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_addr  = a;
        o_wdata = (a == 8'h02) ? {d[7:1], 1'b0} : d;
        o_wr    = 1'b1;
        @(negedge i_clk_sys);
        o_wr    = 1'b0;
        o_wdata = ~o_wdata; // released data must not keep its last value
    endtask

    // one read strobe; the answer is awaited for a bounded time
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        bit got;
        got = 1'b0;
        d   = 8'h00;
        @(negedge i_clk_sys);
        o_addr = a;
        o_rd   = 1'b1;
        @(negedge i_clk_sys);
        o_rd   = 1'b0;
        for (int n = 0; n < 4 && !got; n++) begin
            if (i_rvalid === 1'b1) begin
                d   = i_rdata;
                got = 1'b1;
            end else begin
                @(negedge i_clk_sys);
            end
        end
        if (!got) begin
            d = 8'hEE; // no answer: a value the identifier and input format registers never show
        end
    endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the format and output control register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [7:0] PID = 8'hA6; // arbitrary identifier value
    logic        i_clk_sys = 1'b0;
    logic        i_reset   = 1'b1;
    logic [1:0]  det       = 2'h0;
    logic [15:0] pix       = 16'h0000;
    logic [6:0]  tim       = 7'h00;
    logic [7:0]  addr, wdata, rdata, in_reg, of_reg, pc_reg, d;
    logic        wr, rd, rvalid, ped, slice, gam_en, pix_oe, tim_oe;
    logic [1:0]  std_o, gam, csel, std_w;
    logic [2:0]  pfmt;
    logic [15:0] pbus;
    logic [6:0]  tim_o;
    logic [31:0] seed      = 32'h0000002F;
    int          fail_count = 0;
    int          n_tests    = 0;
    int          cycles     = 0;

    always #2 i_clk_sys = ~i_clk_sys;

    host_model u_host (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

    fmt_regs #(.PRODUCT_IDENTIFIER(PID)) u_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_detected_std(det), .i_pixel(pix), .i_timing(tim), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .o_timing_std(std_o), .o_pedestal_75(ped),
        .o_adaptive_slice(slice), .o_pixel_format(pfmt), .o_gamma_sel(gam),
        .o_gamma_en(gam_en), .o_color_sel(csel), .o_pixel_bus(pbus),
        .o_pixel_bus_oe(pix_oe), .o_timing(tim_o), .o_timing_oe(tim_oe));

    // xorshift step for repeatable stimulus
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // expected timing outputs: a set polarity bit passes the level, clear inverts
    function automatic logic [6:0] exp_tim(input logic [7:0] pc, input logic [6:0] t);
        logic [6:0] p;
        p = {1'b1, pc[1], pc[0], pc[5], pc[4], pc[2], pc[3]};
        return ~(t ^ p);
    endfunction

    function automatic logic is_rgb_code(input logic [2:0] f);
        return (f == 3'h3) || (f == 3'h4);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // register read data against the expected byte
    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t read got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, fail_count);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // all configuration outputs, two cycles after the last write
    task automatic outs();
        repeat (2) @(negedge i_clk_sys);
        chk(std_o, in_reg[4] ? det : std_w);
        chk(ped, in_reg[3]);
        chk(slice, in_reg[0]);
        chk(pfmt, of_reg[7:5]);
        chk(gam_en, is_rgb_code(of_reg[7:5]));
        chk(gam, is_rgb_code(of_reg[7:5]) ? of_reg[4:3] : 2'h0);
        chk(csel, of_reg[2:1]);
        chk(pix_oe, pc_reg[7]);
        chk(tim_oe, pc_reg[6]);
        if (pc_reg[7]) chk(pbus, pix);
        if (pc_reg[6]) chk(tim_o, exp_tim(pc_reg, tim));
    endtask

    // write one register and track what the bank must now hold
    task automatic put(input logic [7:0] a, input logic [7:0] v);
        u_host.wr(a, v);
        case (a)
            8'h01: begin
                if (!in_reg[4] && !v[4]) std_w = v[6:5];
                in_reg = v & 8'h19;
            end
            8'h02: of_reg = {v[7:1], 1'b0};
            8'h03: pc_reg = v;
            default: ;
        endcase
        outs();
    endtask

    // read every mapped register and one unmapped place
    task automatic readall();
        u_host.rd(8'h00, d);
        chk_rd(d, PID);
        u_host.rd(8'h01, d);
        chk_rd(d, {1'b0, (in_reg[4] ? det : std_w), in_reg[4:3], 2'h0, in_reg[0]});
        u_host.rd(8'h02, d);
        chk_rd(d, of_reg);
        u_host.rd(8'h03, d);
        chk_rd(d, pc_reg);
        u_host.rd(8'h07, d);
        chk_rd(d, 8'h00);
    endtask

    task automatic do_reset();
        i_reset = 1'b1;
        in_reg  = 8'h19;
        of_reg  = 8'h00;
        pc_reg  = 8'h00;
        std_w   = 2'h0;
        repeat (10) @(negedge i_clk_sys);
        i_reset = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        outs();
        readall();
    endtask

    // hang guard
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    initial begin
        det = 2'h2;
        do_reset();
        end_test("reset");
        put(8'h00, ~PID);
        put(8'h07, 8'hFF);
        readall();
        end_test("read_only_and_unmapped");
        put(8'h01, 8'hFF);
        for (int k = 0; k < 4; k++) begin
            det = k[1:0];
            repeat (4) @(negedge i_clk_sys);
            put(8'h01, {1'b1, ~k[1:0], 5'h1F});
            readall();
        end
        put(8'h01, 8'h08);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            put(8'h01, {seed[7], k[1:0], 1'b0, seed[3:0]});
            readall();
        end
        put(8'h01, 8'hFF);
        end_test("input_format");
        for (int f = 0; f < 8; f++) begin // reserved codes 5..7 included
            for (int g = 0; g < 4; g++) begin
                put(8'h02, {f[2:0], g[1:0], g[1:0], 1'b1});
            end
            readall();
        end
        end_test("output_format");
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            pix  = seed[15:0];
            tim  = seed[22:16];
            d    = (i < 4) ? {i[1:0], 6'h3F} ^ 8'h3F : seed[31:24];
            put(8'h03, (i == 4) ? 8'hFF : d);
        end
        readall();
        end_test("output_control");
        do_reset();
        end_test("mid_run_reset");
        print_verdict();
    end
endmodule
`default_nettype wire
